// >>> hw/rst_seq_defs.svh
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH
// Register byte offsets on the APB bus.
`define OFS_CAUSE      12'h000
`define OFS_STATUS     12'h004
`define OFS_CONFIG     12'h008
// Field positions in the reset cause register.
`define BIT_TRAP       15
`define BIT_ILLEGAL    14
`define BIT_CFGMIS     9
`define BIT_VREG       8
`define BIT_PIN        7
`define BIT_SOFT       6
`define BIT_WDTEN      5
`define BIT_WATCHDOG_TIMEOUT_FLAG       4
`define BIT_SLEEP      3
`define BIT_IDLE       2
`define BIT_BROWN      1
`define BIT_POWER      0
// Writable and implemented bits of the cause register.
`define CAUSE_MASK     16'hc3ff
// Reset value after power-on.
`define CAUSE_POR_VAL  16'h0003
// Timing figures in their own units.
`define CLK_MHZ        100
`define T_POR_US       30
`define T_BOR_US       100
`define T_LOCK_US      1500
`define T_MON_US       900
`define OST_PERIODS    1024
`define RESET_VECTOR   24'h000000
`endif

// >>> hw/rst_seq_pkg.sv
package rst_seq_pkg;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_SUPPLY, ST_EXTEND, ST_POWERUP_TIMER, ST_OSC, ST_LOCK, ST_RUN, ST_SOFT
  } seq_state_t;
endpackage

// >>> hw/delay_counter.sv
`timescale 1ns/10ps
`default_nettype none
// Down counter that loads a cycle count on start and pulses done at zero.
module delay_counter #(
  parameter int W = 24
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_count,
  input  wire logic         i_tick,
  output logic              o_done
);
  logic [W-1:0] cnt_r;  // Remaining ticks.
  logic         busy_r; // Counting in progress.
  wire          last = busy_r && i_tick && (cnt_r <= W'(1));
  // A start restarts the count even while busy, so a new cause re-extends.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= last || (i_start && i_count == '0);
      if (i_start) begin
        cnt_r  <= i_count;
        busy_r <= (i_count != '0);
      end else if (last) begin
        busy_r <= 1'b0;
      end else if (busy_r && i_tick) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/oscillator_edge.sv
`timescale 1ns/10ps
`default_nettype none
// Turns a slow oscillator level, sampled on the system clock, into a tick.
module oscillator_edge (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_osc,
  output logic      o_tick
);
  logic osc_q_r; // Previous sample.
  // Inputs are synchronous to the system clock, so one flop suffices.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      osc_q_r <= 1'b0;
      o_tick  <= 1'b0;
    end else begin
      osc_q_r <= i_osc;
      o_tick  <= i_osc && !osc_q_r;
    end
  end
endmodule
`default_nettype wire

// >>> hw/reset_cause_and_startup_sequencer.sv
`include "rst_seq_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module reset_cause_and_startup_sequencer
  import rst_seq_pkg::*;
#(
  parameter int unsigned POWERUP_TIMER_SCALE_CYC = 100000, // Cycles per power-up timer ms step.
  parameter int unsigned LOCK_CYC       = `T_LOCK_US * `CLK_MHZ,
  parameter int unsigned MON_CYC        = `T_MON_US * `CLK_MHZ
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_SYS_RST,
  // APB slave.
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic [31:0]      O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Supply detectors, high while the supply is good.
  input  wire logic        I_POWER_GOOD,
  input  wire logic        I_BROWNOUT_GOOD,
  // Reset sources, one-cycle pulses.
  input  wire logic        I_TRAP_CONFLICT,
  input  wire logic        I_ILLEGAL_CONDITION,
  input  wire logic        I_CONFIG_MISMATCH,
  input  wire logic        I_MASTER_CLEAR_PIN_N,
  input  wire logic        I_SOFT_RESET,
  input  wire logic        I_WATCHDOG_TIMEOUT,
  input  wire logic        I_WATCHDOG_WAKE,
  input  wire logic        I_SLEEP_ENTER,
  input  wire logic        I_IDLE_ENTER,
  input  wire logic        I_WATCHDOG_CLEAR,
  // Nonvolatile configuration.
  input  wire logic        I_NV_WATCHDOG_ENABLE,
  input  wire logic [2:0]  I_NV_OSCILLATOR_SELECT,
  input  wire logic [2:0]  I_POWERUP_TIMER,
  input  wire logic        I_MONITOR_ENABLE,
  input  wire logic        I_OSC_CLK,
  // Core side.
  output logic             O_SYSTEM_RESET_N,
  output logic             O_OSC_ENABLE,
  output logic [2:0]       O_CURRENT_OSCILLATOR_FIELD,
  output logic             O_CLOCK_READY,
  output logic [23:0]      O_FETCH_ADDR,
  output logic             O_WATCHDOG_RUN,
  output logic             O_REGULATOR_SLEEP_ACTIVE,
  output logic             O_MONITOR_ACTIVE
);
  // Extension times in system clock cycles, taken at their upper limit.
  localparam int unsigned POR_CYC = `T_POR_US * `CLK_MHZ; // Longest time, floors.
  localparam int unsigned BOR_CYC = `T_BOR_US * `CLK_MHZ;
  // The main and monitor counters are 24 bits wide, so longer delays are refused at elaboration.
  if (POWERUP_TIMER_SCALE_CYC == 0 || LOCK_CYC == 0 || MON_CYC == 0 ||
      LOCK_CYC >= (1 << 24) || MON_CYC >= (1 << 24) ||
      POWERUP_TIMER_SCALE_CYC * 128 >= (1 << 24)) begin : g_param_check
    $error("Delay parameters out of counter range.");
  end
  // Oscillator modes: 0 internal, 1 internal PLL, 2 crystal, 3 crystal PLL,
  // 4 secondary, 5 external, 6 external PLL, 7 low-power internal.
  // The sequence walks supply, extension and power-up timer before the core leaves
  // reset, then oscillator start-up and PLL lock. A supply fault restarts it from
  // the top and counts as a cold start, while a warm cause re-enters at the
  // power-up timer with the oscillator left running.
  // The extension, power-up timer and lock delays share one down counter, since only one is ever active.
  // The oscillator start-up count has its own counter because it is paced by
  // oscillator edges rather than by the system clock.
  // The monitor delay has a counter of its own as well, since it runs after
  // the core is already out of reset and must not disturb the main one.
  // Sequencer state and the registers it owns.
  seq_state_t  state_r;         // Sequencer state.
  logic [15:0] cause_r;         // Reset cause and control register.
  logic        cold_r;          // Current sequence started from a cold cause.
  logic [2:0]  osc_r;           // Oscillator in use.
  logic        start_r;         // One-cycle start for the delay counter.
  logic [23:0] load_r;          // Count loaded with the start.
  logic        ost_start_r;     // Start for the oscillator start-up counter.
  logic        mon_start_r;     // Start for the monitor delay.
  logic        mon_done;        // Monitor delay elapsed.
  logic        dly_done;        // Main delay elapsed.
  logic        ost_done;        // 1024 oscillator periods counted.
  logic        osc_tick;        // One oscillator period.
  // Address decode. Only a full 12-bit match selects a register, so aliases
  // of the three words answer with an error rather than with stale data.
  wire         acc      = I_PSEL && I_PENABLE;
  wire         hit_cau  = I_PADDR == `OFS_CAUSE;
  wire         hit_sts  = I_PADDR == `OFS_STATUS;
  wire         hit_cfg  = I_PADDR == `OFS_CONFIG;
  wire         wr_cause = acc && I_PWRITE && hit_cau;
  wire         mapped   = hit_cau || hit_sts || hit_cfg;
  // Warm causes that pull reset right away. Sleep and idle entry only mark
  // the register and never restart the sequence.
  wire         warm_evt = I_TRAP_CONFLICT || I_ILLEGAL_CONDITION || I_CONFIG_MISMATCH ||
                          !I_MASTER_CLEAR_PIN_N || I_WATCHDOG_TIMEOUT;
  // A power loss hides any brown-out, so brown-out is seen only with power good.
  wire         por_now  = !I_POWER_GOOD;
  wire         bor_now  = I_POWER_GOOD && !I_BROWNOUT_GOOD;
  wire         in_run   = state_r == ST_RUN;
  // Mode groups: which modes need a start-up count and which a PLL lock.
  wire         crystal  = osc_r == 3'd2 || osc_r == 3'd3 || osc_r == 3'd4;
  wire         pll      = osc_r == 3'd1 || osc_r == 3'd3 || osc_r == 3'd6;
  // Power-up timer: setting zero skips the wait, each step above it doubles it.
  wire [23:0]  powerup_timer_cyc = (I_POWERUP_TIMER == 3'd0) ? 24'h0 :
                          24'((32'd1 << (I_POWERUP_TIMER - 3'd1)) * POWERUP_TIMER_SCALE_CYC);
  wire [15:0]  wr_val   = I_PWDATA[15:0] & `CAUSE_MASK;
  // Hardware set terms, one per flag; these win over a software clear.
  logic [15:0] set_bits;
  always_comb begin
    set_bits = 16'h0000;
    set_bits[`BIT_TRAP]    = I_TRAP_CONFLICT;
    set_bits[`BIT_ILLEGAL] = I_ILLEGAL_CONDITION;
    set_bits[`BIT_CFGMIS]  = I_CONFIG_MISMATCH;
    set_bits[`BIT_PIN]     = !I_MASTER_CLEAR_PIN_N;
    set_bits[`BIT_SOFT]    = I_SOFT_RESET && in_run;
    set_bits[`BIT_WATCHDOG_TIMEOUT_FLAG]    = I_WATCHDOG_TIMEOUT || I_WATCHDOG_WAKE;
    set_bits[`BIT_SLEEP]   = I_SLEEP_ENTER;
    set_bits[`BIT_IDLE]    = I_IDLE_ENTER;
    set_bits[`BIT_BROWN]   = bor_now;
  end
  // Cause register. Power loss loads the power-on value; other causes only
  // add their own flag. A software write stores only and never resets.
  // The set terms are ORed in after the write value, so a hardware event in
  // the same cycle as a software clear is never lost.
  // The watchdog clear only touches its own flag and also yields to a set.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST || por_now) begin
      cause_r <= `CAUSE_POR_VAL;
    end else begin
      // Writes are masked so bits 13 to 10 stay zero.
      cause_r <= ((wr_cause ? wr_val : cause_r) | set_bits) & `CAUSE_MASK;
      if (I_WATCHDOG_CLEAR)
        cause_r[`BIT_WATCHDOG_TIMEOUT_FLAG] <= set_bits[`BIT_WATCHDOG_TIMEOUT_FLAG];
    end
  end
  // Delay and oscillator counters.
  // The main counter is restarted by the sequencer for each phase; its tick
  // is tied high because every phase is timed in system clock cycles.
  // The start-up counter counts rising oscillator edges; its tick is not gated by the
  // oscillator enable, and it is started as the power-up timer ends, even on a warm restart where the enable is already high.
  delay_counter #(.W(24)) u_delay (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_SYS_RST),
    .i_start (start_r),
    .i_count (load_r),
    .i_tick  (1'b1),
    .o_done  (dly_done)
  );
  oscillator_edge u_edge (
    .i_clk  (I_CLK_SYS),
    .i_rst  (I_SYS_RST),
    .i_osc  (I_OSC_CLK),
    .o_tick (osc_tick)
  );
  delay_counter #(.W(11)) u_ost (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_SYS_RST),
    .i_start (ost_start_r),
    .i_count (11'(`OST_PERIODS)),
    .i_tick  (osc_tick),
    .o_done  (ost_done)
  );
  delay_counter #(.W(24)) u_mon (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_SYS_RST),
    .i_start (mon_start_r),
    .i_count (24'(MON_CYC)),
    .i_tick  (1'b1),
    .o_done  (mon_done)
  );
  // Sequencer. Supply faults override everything and restart from the top.
  // The start strobes are single-cycle pulses, cleared by default on every
  // cycle, so a phase never retriggers its counter twice.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      state_r     <= ST_SUPPLY;
      cold_r      <= 1'b1;
      osc_r       <= 3'd0;
      start_r     <= 1'b0;
      load_r      <= 24'(POR_CYC); // A system reset is a power-on start.
      ost_start_r <= 1'b0;
      mon_start_r <= 1'b0;
    end else begin
      start_r     <= 1'b0;
      ost_start_r <= 1'b0;
      mon_start_r <= 1'b0;
      if (por_now || bor_now) begin
        state_r <= ST_SUPPLY;
        cold_r  <= 1'b1;
        load_r  <= por_now ? 24'(POR_CYC) : 24'(BOR_CYC);
      end else begin
        case (state_r)
          // Supply good again: start the extension delay.
          ST_SUPPLY: begin
            // Supply is back: run the extension delay.
            start_r <= 1'b1;
            state_r <= ST_EXTEND;
          end
          // Wait out the extension, then load the power-up timer.
          ST_EXTEND: begin
            if (dly_done) begin
              load_r  <= powerup_timer_cyc;
              start_r <= 1'b1;
              state_r <= ST_POWERUP_TIMER;
            end
          end
          // Power-up timer running; the clock is chosen when it ends.
          ST_POWERUP_TIMER: begin
            if (dly_done) begin
              // Cold start reads the nonvolatile select; warm keeps the clock.
              if (cold_r)
                osc_r <= I_NV_OSCILLATOR_SELECT;
              ost_start_r <= 1'b1;
              state_r     <= ST_OSC;
            end
          end
          // Wait for the start-up count, if the mode needs one.
          ST_OSC: begin
            // External clock needs no start-up count.
            if (!crystal || ost_done) begin
              load_r  <= 24'(LOCK_CYC);
              start_r <= pll;
              state_r <= pll ? ST_LOCK : ST_RUN;
              mon_start_r <= !pll;
            end
          end
          // PLL modes stay here until the lock time has passed.
          ST_LOCK: begin
            if (dly_done) begin
              state_r     <= ST_RUN;
              mon_start_r <= 1'b1;
            end
          end
          // Running: a software reset wins over a warm cause in the same cycle.
          ST_RUN: begin
            cold_r <= 1'b0;
            if (I_SOFT_RESET) begin
              state_r <= ST_SOFT;
            end else if (warm_evt) begin
              // Warm causes rerun the timer but keep the oscillator.
              cold_r  <= 1'b0;
              load_r  <= powerup_timer_cyc;
              start_r <= 1'b1;
              state_r <= ST_POWERUP_TIMER;
            end
          end
          // The software reset state lasts exactly one cycle.
          ST_SOFT: begin
            // One cycle of reset, clock untouched, then fetch again.
            state_r     <= ST_RUN;
            mon_start_r <= 1'b1;
          end
          // An unused encoding falls back to a full restart.
          default: state_r <= ST_SUPPLY;
        endcase
      end
    end
  end
  // Core outputs, all registered.
  // Every output comes straight from a flop, so the core sees each decision
  // one cycle after the sequencer takes it.
  // During a warm restart the oscillator enable stays high; crystal modes still
  // rerun the start-up count on a clock that never stopped.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_SYSTEM_RESET_N           <= 1'b0;
      O_OSC_ENABLE               <= 1'b0;
      O_CURRENT_OSCILLATOR_FIELD <= 3'd0;
      O_CLOCK_READY              <= 1'b0;
      O_FETCH_ADDR               <= `RESET_VECTOR;
      O_WATCHDOG_RUN             <= 1'b0;
      O_REGULATOR_SLEEP_ACTIVE   <= 1'b0;
      O_MONITOR_ACTIVE           <= 1'b0;
    end else begin
      // Reset releases once the power-up timer ends, as the oscillator starts.
      O_SYSTEM_RESET_N <= state_r == ST_OSC || state_r == ST_LOCK || in_run;
      O_OSC_ENABLE     <= state_r == ST_OSC || state_r == ST_LOCK || in_run ||
                          (!cold_r && state_r == ST_POWERUP_TIMER) || state_r == ST_SOFT;
      O_CURRENT_OSCILLATOR_FIELD <= osc_r;
      O_CLOCK_READY    <= in_run;
      O_FETCH_ADDR     <= `RESET_VECTOR;
      // The nonvolatile enable forces the watchdog on whatever software writes.
      O_WATCHDOG_RUN   <= I_NV_WATCHDOG_ENABLE || cause_r[`BIT_WDTEN];
      O_REGULATOR_SLEEP_ACTIVE <= cause_r[`BIT_VREG];
      // The monitor drops at once when the core leaves run or it is disabled.
      if (!in_run || !I_MONITOR_ENABLE)
        O_MONITOR_ACTIVE <= 1'b0;
      else if (mon_done)
        O_MONITOR_ACTIVE <= 1'b1;
    end
  end
  // APB: zero wait states; unmapped addresses answer with an error.
  // Ready is raised in the first access cycle, so a master never waits.
  // Read data are zero outside that cycle, which keeps stale values off the bus.
  // Writes to the status and configuration words are ignored; both are views
  // of live state and nothing in them can be stored.
  // Status carries the monitor, ready and cold flags above the oscillator in
  // use; configuration mirrors the nonvolatile inputs.
  wire [31:0] rd_mux = hit_cau ? {16'h0000, cause_r} :
                       hit_sts ? {24'h0, O_MONITOR_ACTIVE, O_CLOCK_READY, cold_r,
                                  2'b00, osc_r} :
                       hit_cfg ? {23'h0, I_POWERUP_TIMER, 2'b00, I_NV_WATCHDOG_ENABLE,
                                  I_NV_OSCILLATOR_SELECT} : 32'h0;
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      O_PRDATA  <= 32'h0;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= I_PSEL && !I_PENABLE;
      O_PSLVERR <= I_PSEL && !I_PENABLE && !mapped;
      O_PRDATA  <= (I_PSEL && !I_PENABLE && !I_PWRITE) ? rd_mux : 32'h0;
    end
  end
endmodule
`default_nettype wire

// >>> sim/osc_source.sv
`timescale 1ns/10ps
`default_nettype none
// Crystal stand-in: a slow square wave that only swings while enabled.
module osc_source #(
  parameter int HALF = 2 // Cycles per half period; raise it for a slow crystal.
) (
  input  wire logic i_clk,
  input  wire logic i_enable,
  output logic      o_osc
);
  int cnt_r; // Half-period counter.
  initial o_osc = 1'b0;
  initial cnt_r = 0;
  // A disabled oscillator stands still, so no period is counted early.
  always @(posedge i_clk) begin
    if (!i_enable) begin
      o_osc <= 1'b0;
      cnt_r <= 0;
    end else if (cnt_r == HALF - 1) begin
      o_osc <= ~o_osc;
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule
`default_nettype wire

// >>> sim/rst_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the reset sequencer.
module rst_seq_asserts #(
  parameter int unsigned MON_CYC = 20
) (
  input wire logic        I_CLK_SYS,
  input wire logic        I_SYS_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic        I_POWER_GOOD,
  input wire logic        I_BROWNOUT_GOOD,
  input wire logic        I_SOFT_RESET,
  input wire logic        I_NV_WATCHDOG_ENABLE,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_SYSTEM_RESET_N,
  input wire logic [2:0]  O_CURRENT_OSCILLATOR_FIELD,
  input wire logic        O_CLOCK_READY,
  input wire logic [23:0] O_FETCH_ADDR,
  input wire logic        O_WATCHDOG_RUN,
  input wire logic        O_MONITOR_ACTIVE
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);
  logic [15:0] rdy_cnt_r; // Cycles since the clock became ready.
  // Saturating so a long run never wraps back into the legal window.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST || !O_CLOCK_READY) rdy_cnt_r <= 16'h0000;
    else if (rdy_cnt_r != 16'hffff) rdy_cnt_r <= rdy_cnt_r + 16'h0001;
  end
  AST_FETCH_ZERO: assert property (O_FETCH_ADDR == 24'h000000)
    else $error("fetch address not zero");
  AST_WDT_FORCED: assert property ($past(I_NV_WATCHDOG_ENABLE) && !$past(I_SYS_RST)
    |-> O_WATCHDOG_RUN) else $error("watchdog not forced on");
  AST_SOFT_ASSERT: assert property (I_SOFT_RESET && O_CLOCK_READY && O_SYSTEM_RESET_N
    && I_POWER_GOOD && I_BROWNOUT_GOOD |-> ##[1:3] !O_SYSTEM_RESET_N)
    else $error("soft reset did not reach the core");
  AST_SOFT_KEEP_OSC: assert property (I_SOFT_RESET && O_CLOCK_READY
    |=> $stable(O_CURRENT_OSCILLATOR_FIELD) [*4]) else $error("soft reset moved clock");
  AST_MON_DELAY: assert property ($rose(O_MONITOR_ACTIVE) |-> O_CLOCK_READY
    && rdy_cnt_r + 2 >= MON_CYC && rdy_cnt_r <= MON_CYC + 3)
    else $error("monitor start delay wrong");
  AST_APB_ANSWER: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("apb answer missing");
  AST_RSVD_ZERO: assert property (O_PREADY && !I_PWRITE && I_PADDR == 12'h000
    |-> O_PRDATA[31:16] == 16'h0000 && O_PRDATA[13:10] == 4'h0)
    else $error("unimplemented bits read nonzero");
  AST_SUPPLY_HOLD: assert property (!I_POWER_GOOD || !I_BROWNOUT_GOOD
    |-> ##[1:2] !O_SYSTEM_RESET_N) else $error("core not held on supply fault");
endmodule
bind reset_cause_and_startup_sequencer rst_seq_asserts #(.MON_CYC(MON_CYC)) u_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_POWER_GOOD(I_POWER_GOOD),
  .I_BROWNOUT_GOOD(I_BROWNOUT_GOOD), .I_SOFT_RESET(I_SOFT_RESET),
  .I_NV_WATCHDOG_ENABLE(I_NV_WATCHDOG_ENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_SYSTEM_RESET_N(O_SYSTEM_RESET_N), .O_CLOCK_READY(O_CLOCK_READY),
  .O_CURRENT_OSCILLATOR_FIELD(O_CURRENT_OSCILLATOR_FIELD), .O_FETCH_ADDR(O_FETCH_ADDR),
  .O_WATCHDOG_RUN(O_WATCHDOG_RUN), .O_MONITOR_ACTIVE(O_MONITOR_ACTIVE)
);
`default_nettype wire

// >>> sim/test_reset_cause_and_startup_sequencer.sv
`include "rst_seq_defs.svh"
`timescale 1ns/10ps
`default_nettype none
// Register and sequence tests of the reset sequencer.
module test_reset_cause_and_startup_sequencer;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic        pready, pslverr, pg = 1'b1, bg = 1'b1, nv_wdt = 1'b0, osc;
  logic [9:0]  src = 10'h000; // Reset and event sources, one bit each.
  logic [2:0]  nv_osc = 3'h3, cur_osc, powerup_timer_sel = 3'h2;
  logic        rst_n, osc_en, ready, wdt_run, vreg, mon, mon_en = 1'b1;
  logic [23:0] fetch;
  int          fails = 0, cmp_count = 0, cyc = 0;
  int          fb [8] = '{15, 14, 9, 7, 6, 4, 3, 2}; // Flag bit of each source.
  wire logic [2:0] obs = {mon, ready, rst_n}; // Sequence milestones.
  always #5 clk = ~clk;
  // Short power-up timer and lock counts keep the run brief.
  reset_cause_and_startup_sequencer #(.POWERUP_TIMER_SCALE_CYC(10), .LOCK_CYC(20), .MON_CYC(20)) dut (
    .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_POWER_GOOD(pg), .I_BROWNOUT_GOOD(bg), .I_TRAP_CONFLICT(src[0]),
    .I_ILLEGAL_CONDITION(src[1]), .I_CONFIG_MISMATCH(src[2]), .I_MASTER_CLEAR_PIN_N(~src[3]),
    .I_SOFT_RESET(src[4]), .I_WATCHDOG_TIMEOUT(src[5]), .I_SLEEP_ENTER(src[6]),
    .I_IDLE_ENTER(src[7]), .I_WATCHDOG_WAKE(src[8]), .I_WATCHDOG_CLEAR(src[9]),
    .I_NV_WATCHDOG_ENABLE(nv_wdt), .I_NV_OSCILLATOR_SELECT(nv_osc), .I_POWERUP_TIMER(powerup_timer_sel),
    .I_MONITOR_ENABLE(mon_en), .I_OSC_CLK(osc), .O_SYSTEM_RESET_N(rst_n), .O_OSC_ENABLE(osc_en),
    .O_CURRENT_OSCILLATOR_FIELD(cur_osc), .O_CLOCK_READY(ready), .O_FETCH_ADDR(fetch),
    .O_WATCHDOG_RUN(wdt_run), .O_REGULATOR_SLEEP_ACTIVE(vreg), .O_MONITOR_ACTIVE(mon)
  );
  osc_source #(.HALF(2)) u_osc (.i_clk(clk), .i_enable(osc_en), .o_osc(osc));
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi) begin
      fails++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No limit here: only the bench timeout may end a wait.
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never reassigns psel in this step.
    @(posedge clk);
  endtask
  // Counts cycles until a milestone is reached, bounded so a hang cannot stall.
  task automatic wait_for(input int s, output int n);
    n = 0;
    while (obs[s] !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      summarize();
    end
  end
  initial begin
    int n;
    logic [31:0] q, ex;
    logic e;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_for(0, n);
    chk_rng("por release", 3018, 3030, n);
    wait_for(1, n);
    chk_rng("osc ready", 4100, 4150, n);
    wait_for(2, n);
    chk_rng("monitor start", 17, 25, n);
    chk("cold osc", 32'h3, cur_osc);
    chk("fetch", 32'h0, fetch);
    apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
    chk("cause por", 32'h00000003, q);
    apb(`OFS_CAUSE, 1'b1, 32'hffffffff, q, e);
    apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
    chk("cause set", 32'h0000c3ff, q);
    chk("no reset", 32'h1, rst_n);
    chk("regulator on", 32'h1, vreg);
    chk("watchdog sw", 32'h1, wdt_run);
    apb(`OFS_CAUSE, 1'b1, 32'h0, q, e);
    apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
    chk("cause clear", 32'h0, q);
    chk("regulator off", 32'h0, vreg);
    chk("watchdog off", 32'h0, wdt_run);
    nv_wdt <= 1'b1;
    repeat (3) @(posedge clk);
    chk("watchdog nv", 32'h1, wdt_run);
    nv_wdt <= 1'b0;
    apb(12'h00c, 1'b0, 32'h0, q, e);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, q);
    // Warm, soft, sleep and idle flags pile up; a changed select must not move the running clock.
    nv_osc <= 3'h0;
    ex = 32'h0;
    for (int i = 0; i < 8; i++) begin
      src[i] <= 1'b1;
      repeat ((i == 3) ? 3 : 1) @(posedge clk);
      src[i] <= 1'b0;
      repeat (4) @(posedge clk);
      wait_for(0, n);
      wait_for(1, n);
      ex[fb[i]] = 1'b1;
      apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
      chk("warm flags", ex, q);
    end
    chk("warm osc", 32'h3, cur_osc);
    src[9] <= 1'b1;
    @(posedge clk);
    src[9] <= 1'b0;
    ex[4] = 1'b0;
    apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
    chk("wdt clear", ex, q);
    src[8] <= 1'b1;
    @(posedge clk);
    src[8] <= 1'b0;
    ex[4] = 1'b1;
    apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
    chk("wdt wake", ex, q);
    bg <= 1'b0;
    repeat (5) @(posedge clk);
    bg <= 1'b1;
    wait_for(0, n);
    chk_rng("bor release", 10018, 10030, n);
    wait_for(1, n);
    ex[1] = 1'b1;
    apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
    chk("bor flags", ex, q);
    chk("bor osc", 32'h0, cur_osc);
    // Power-on again with no power-up timer and the clock monitor disabled.
    powerup_timer_sel <= 3'h0;
    mon_en <= 1'b0;
    pg <= 1'b0;
    repeat (5) @(posedge clk);
    pg <= 1'b1;
    wait_for(0, n);
    chk_rng("por again", 3000, 3010, n);
    wait_for(1, n);
    repeat (30) @(posedge clk);
    chk("monitor off", 32'h0, mon);
    apb(`OFS_CAUSE, 1'b0, 32'h0, q, e);
    chk("por flags", 32'h00000003, q);
    summarize();
  end
endmodule
`default_nettype wire
